// *** src/radio_cfg_pkg.sv ***
// Shared constants for the serial configuration link of the radio module
package radio_cfg_pkg;
  // Clock and serial timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int BIT_CYC_W    = 14;
  localparam int BAUD_9600    = 9600;
  localparam int BAUD_19200   = 19200;
  localparam int BAUD_38400   = 38400;
  localparam int BAUD_57600   = 57600;
  localparam int BAUD_115200  = 115200;
  localparam int BAUD_10400   = 10400;
  localparam int BAUD_31250   = 31250;
  localparam int REPLY_WAIT_MS = 20;

  // Frame bytes
  localparam logic [7:0] FRAME_HEADER = 8'hFF;
  localparam logic [7:0] FRAME_SIZE   = 8'h02;
  localparam logic [7:0] READ_ESCAPE  = 8'hFE;
  localparam logic [7:0] REPLY_ACK    = 8'h06;
  localparam logic [7:0] REPLY_NACK   = 8'h15;

  // Register locations
  localparam logic [7:0] POWER_LEVEL_SAVED       = 8'h02;
  localparam logic [7:0] SERIAL_RATE_SAVED       = 8'h03;
  localparam logic [7:0] ADDRESSING_STYLE_SAVED  = 8'h04;
  localparam logic [7:0] SEND_WAIT_TIMEOUT_SAVED = 8'h05;
  localparam logic [7:0] POWER_LEVEL_LIVE        = 8'h4D;
  localparam logic [7:0] SERIAL_RATE_LIVE        = 8'h4E;
  localparam logic [7:0] ADDRESSING_STYLE_LIVE   = 8'h4F;
  localparam logic [7:0] SEND_WAIT_TIMEOUT_LIVE  = 8'h50;
  localparam int         SETTING_COUNT           = 4;

  // Setting slots inside each bank
  localparam logic [1:0] SLOT_POWER = 2'h0;
  localparam logic [1:0] SLOT_RATE  = 2'h1;
  localparam logic [1:0] SLOT_ADDR  = 2'h2;
  localparam logic [1:0] SLOT_WAIT  = 2'h3;

  // Factory values and legal codes
  localparam logic [7:0] POWER_DEFAULT  = 8'h03;
  localparam logic [7:0] RATE_DEFAULT   = 8'h01;
  localparam logic [7:0] ADDR_DEFAULT   = 8'h00;
  localparam logic [7:0] WAIT_DEFAULT   = 8'h00;
  localparam logic [7:0] POWER_MAX      = 8'h03;
  localparam logic [7:0] RATE_MIN       = 8'h01;
  localparam logic [7:0] RATE_MAX       = 8'h07;
  localparam logic [7:0] RATE_FAST_MIN  = 8'h03;
  localparam logic [7:0] RATE_HOPHI_MAX = 8'h05;
  localparam logic [7:0] RATE_PC_UNSAFE = 8'h06;

  // Clock cycles per serial bit for a rate code
  function automatic logic [BIT_CYC_W-1:0] bit_cycles(input logic [7:0] code, input int clkHz);
    unique case (code)
      8'h02:   bit_cycles = BIT_CYC_W'(clkHz / BAUD_19200);
      8'h03:   bit_cycles = BIT_CYC_W'(clkHz / BAUD_38400);
      8'h04:   bit_cycles = BIT_CYC_W'(clkHz / BAUD_57600);
      8'h05:   bit_cycles = BIT_CYC_W'(clkHz / BAUD_115200);
      8'h06:   bit_cycles = BIT_CYC_W'(clkHz / BAUD_10400);
      8'h07:   bit_cycles = BIT_CYC_W'(clkHz / BAUD_31250);
      default: bit_cycles = BIT_CYC_W'(clkHz / BAUD_9600);
    endcase
  endfunction
endpackage

// *** src/serial_link_if.sv ***
// Two serial wires joining the host end and the radio end
`timescale 1ns/100ps
`default_nettype none
interface serial_link_if;
  logic hostTx;
  logic radioTx;
  modport radioEnd (input hostTx, output radioTx);
  modport hostEnd (input radioTx, output hostTx);
endinterface
`default_nettype wire

// *** src/radio_cfg_end.sv ***
// Radio end: serial port and configuration register bank
// Summary of operation
// - Power level at live 0x4D, saved 0x02
// - Power codes 0x00..0x03, lowest to highest
// - Factory power code is 0x03
// - Read frame: FF, 02, FE, location
// - Read reply: ACK 06, location, value
// - Write frame: FF, 02, location, value
// - Host must not write addressing style
// - Send wait timeout stored, has no effect
// - Serial rate at live 0x4E, saved 0x03
// - Saved rate applies only after reset
// - Live rate switches after acknowledgement sent
// - Rate codes map baud and radio rate
// - Factory serial rate code 0x01, 9600 baud
// - Host matches rate or hunts all rates
// - Hop set chosen from serial rate
// - PC hosts avoid codes 0x06, 0x07
`timescale 1ns/100ps
`default_nettype none

module serial_port
  import radio_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Bit timing
  input  wire logic [BIT_CYC_W-1:0] bitCycles,
  // Line pins
  input  wire logic                 rxPin,
  output logic                      txPin,
  // Byte side
  output logic                      rxValid,
  output logic [7:0]                rxByte,
  input  wire logic                 txStart,
  input  wire logic [7:0]           txByte,
  output logic                      txBusy
);
  logic [2:0]           rxSync;
  logic                 rxLevel;
  logic                 rxActive;
  logic [3:0]           rxBit;
  logic [BIT_CYC_W-1:0] rxCount;
  logic [8:0]           txShift;
  logic [3:0]           txBit;
  logic [BIT_CYC_W-1:0] txCount;

  // Three-stage synchroniser, level moves only when last two agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxSync  <= 3'h7;
      rxLevel <= 1'b1;
    end else begin
      rxSync <= {rxSync[1:0], rxPin};
      if (rxSync[1] == rxSync[2]) rxLevel <= rxSync[2];
    end
  end

  // Receiver: half a bit to mid start, then one bit per sample
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxActive <= 1'b0;
      rxBit    <= 4'h0;
      rxCount  <= '0;
      rxByte   <= 8'h00;
      rxValid  <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (!rxActive) begin
        if (!rxLevel) begin
          rxActive <= 1'b1;
          rxBit    <= 4'h0;
          rxCount  <= bitCycles >> 1;
        end
      end else if (rxCount != '0) begin
        rxCount <= rxCount - 1'b1;
      end else begin
        rxCount <= bitCycles - 1'b1;
        rxBit   <= rxBit + 4'h1;
        if (rxBit == 4'h0 && rxLevel) begin
          rxActive <= 1'b0; // Glitch, not a start bit
        end else if (rxBit == 4'h9) begin
          rxActive <= 1'b0;
          rxValid  <= rxLevel; // Bad stop bit drops the byte
        end else if (rxBit != 4'h0) begin
          rxByte <= {rxLevel, rxByte[7:1]};
        end
      end
    end
  end

  // Transmitter: start bit, eight data bits LSB first, stop bit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      txPin   <= 1'b1;
      txShift <= 9'h1FF;
      txBit   <= 4'h0;
      txCount <= '0;
      txBusy  <= 1'b0;
    end else if (!txBusy) begin
      if (txStart) begin
        txBusy  <= 1'b1;
        txPin   <= 1'b0;
        txShift <= {1'b1, txByte};
        txBit   <= 4'h0;
        txCount <= bitCycles - 1'b1;
      end
    end else if (txCount != '0) begin
      txCount <= txCount - 1'b1;
    end else if (txBit == 4'h9) begin
      txBusy <= 1'b0;
    end else begin
      txPin   <= txShift[0];
      txShift <= {1'b1, txShift[8:1]};
      txBit   <= txBit + 4'h1;
      txCount <= bitCycles - 1'b1;
    end
  end
endmodule // serial_port

module radio_cfg_end
  import radio_cfg_pkg::*;
#(
  parameter int CLK_FREQ = CLK_HZ
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Serial link
  serial_link_if.radioEnd link,
  // Application side
  input  wire logic       rebootReq,
  input  wire logic       appAddrWrite,
  input  wire logic [7:0] appAddrValue,
  output logic [1:0]      powerLevelCode,
  output logic [7:0]      serialRateCode,
  output logic            radioRateFast,
  output logic            hopSetHigh,
  output logic [7:0]      addressingStyle
);
  typedef enum logic [2:0] {WAIT_HDR, WAIT_SIZE, WAIT_FIRST, WAIT_RDADDR, WAIT_VALUE,
                            SEND_REPLY} parse_t;

  parse_t     state;
  logic [7:0] saved [SETTING_COUNT];
  logic [7:0] live  [SETTING_COUNT];
  logic [7:0] activeRate;
  logic [7:0] location;
  logic [7:0] reply [3];
  logic [1:0] replyLen;
  logic [1:0] replyIdx;
  logic       replyStarted;
  logic       rateSwitchPending;
  logic       rxValid;
  logic [7:0] rxByte;
  logic       txBusy;
  logic       txStart;
  logic       isSaved;
  logic       isLive;
  logic [1:0] slot;
  logic       valueOk;
  logic [7:0] next_value;

  // Receiver needs eight clocks a bit; slowest rate must fit the bit counter
  if (CLK_FREQ / BAUD_115200 < 8 || CLK_FREQ / BAUD_9600 >= 2 ** BIT_CYC_W) begin : g_clk_check
    $error("CLK_FREQ cannot serve the serial rates");
  end

  // Serial port runs at the active rate, not the live copy
  serial_port port (
    .mclk      (mclk),
    .rstn      (rstn),
    .bitCycles (bit_cycles(activeRate, CLK_FREQ)),
    .rxPin     (link.hostTx),
    .txPin     (link.radioTx),
    .rxValid   (rxValid),
    .rxByte    (rxByte),
    .txStart   (txStart),
    .txByte    (reply[replyIdx]),
    .txBusy    (txBusy)
  );

  // Location decode into bank and slot
  always_comb begin
    isSaved = (location >= POWER_LEVEL_SAVED) && (location <= SEND_WAIT_TIMEOUT_SAVED);
    isLive  = (location >= POWER_LEVEL_LIVE) && (location <= SEND_WAIT_TIMEOUT_LIVE);
    slot    = isLive ? 2'(location - POWER_LEVEL_LIVE) : 2'(location - POWER_LEVEL_SAVED);
  end

  // Only legal codes are stored for power and rate
  always_comb begin
    next_value = rxByte;
    unique case (slot)
      SLOT_POWER: valueOk = rxByte <= POWER_MAX;
      SLOT_RATE:  valueOk = (rxByte >= RATE_MIN) && (rxByte <= RATE_MAX);
      default:    valueOk = 1'b1;
    endcase
  end

  assign txStart = (state == SEND_REPLY) && !txBusy && !replyStarted;

  // Frame parser and reply sequencer; bytes arriving mid-reply are dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state        <= WAIT_HDR;
      location     <= 8'h00;
      reply[0]     <= 8'h00;
      reply[1]     <= 8'h00;
      reply[2]     <= 8'h00;
      replyLen     <= 2'h0;
      replyIdx     <= 2'h0;
      replyStarted <= 1'b0;
    end else if (rebootReq) begin
      state        <= WAIT_HDR;
      replyStarted <= 1'b0;
    end else begin
      unique case (state)
        WAIT_HDR: if (rxValid && rxByte == FRAME_HEADER) state <= WAIT_SIZE;
        WAIT_SIZE:
          if (rxValid) state <= (rxByte == FRAME_SIZE) ? WAIT_FIRST : WAIT_HDR;
        WAIT_FIRST: if (rxValid) begin
          location <= rxByte;
          state    <= (rxByte == READ_ESCAPE) ? WAIT_RDADDR : WAIT_VALUE;
        end
        WAIT_RDADDR: if (rxValid) begin
          location <= rxByte;
          state    <= SEND_REPLY;
          replyIdx <= 2'h0;
          reply[1] <= rxByte;
          if (rxByte >= POWER_LEVEL_LIVE && rxByte <= SEND_WAIT_TIMEOUT_LIVE) begin
            reply[0] <= REPLY_ACK;
            reply[2] <= live[2'(rxByte - POWER_LEVEL_LIVE)];
            replyLen <= 2'h3;
          end else if (rxByte >= POWER_LEVEL_SAVED && rxByte <= SEND_WAIT_TIMEOUT_SAVED) begin
            reply[0] <= REPLY_ACK;
            reply[2] <= saved[2'(rxByte - POWER_LEVEL_SAVED)];
            replyLen <= 2'h3;
          end else begin
            reply[0] <= REPLY_NACK;
            replyLen <= 2'h1;
          end
        end
        WAIT_VALUE: if (rxValid) begin
          state    <= SEND_REPLY;
          replyIdx <= 2'h0;
          replyLen <= 2'h1;
          reply[0] <= ((isSaved || isLive) && valueOk) ? REPLY_ACK : REPLY_NACK;
        end
        SEND_REPLY: begin
          if (txStart) begin
            replyStarted <= 1'b1;
          end else if (replyStarted && !txBusy) begin
            replyStarted <= 1'b0;
            if (replyIdx + 2'h1 == replyLen) state <= WAIT_HDR;
            else replyIdx <= replyIdx + 2'h1;
          end
        end
        default: state <= WAIT_HDR;
      endcase
    end
  end

  // Saved bank: only power-on reset restores factory values
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      saved[SLOT_POWER] <= POWER_DEFAULT;
      saved[SLOT_RATE]  <= RATE_DEFAULT;
      saved[SLOT_ADDR]  <= ADDR_DEFAULT;
      saved[SLOT_WAIT]  <= WAIT_DEFAULT;
    end else if (state == WAIT_VALUE && rxValid && isSaved && valueOk && !rebootReq) begin
      saved[slot] <= next_value;
    end
  end

  // Live bank: host writes, application owns addressing style, reboot reloads
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      live[SLOT_POWER] <= POWER_DEFAULT;
      live[SLOT_RATE]  <= RATE_DEFAULT;
      live[SLOT_ADDR]  <= ADDR_DEFAULT;
      live[SLOT_WAIT]  <= WAIT_DEFAULT;
    end else if (rebootReq) begin
      live <= saved;
    end else begin
      if (state == WAIT_VALUE && rxValid && isLive && valueOk) begin
        live[slot] <= next_value;
      end
      if (appAddrWrite) live[SLOT_ADDR] <= appAddrValue;
    end
  end

  // Rate used by the port moves on reboot, or once the acknowledgement of a live rate write has left
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      activeRate        <= RATE_DEFAULT;
      rateSwitchPending <= 1'b0;
    end else if (rebootReq) begin
      activeRate        <= saved[SLOT_RATE];
      rateSwitchPending <= 1'b0;
    end else begin
      if (state == WAIT_VALUE && rxValid && isLive && slot == SLOT_RATE && valueOk) begin
        rateSwitchPending <= 1'b1;
      end else if (state == SEND_REPLY && replyStarted && !txBusy && rateSwitchPending) begin
        activeRate        <= live[SLOT_RATE];
        rateSwitchPending <= 1'b0;
      end
    end
  end

  // Registered views of the live settings and the active rate for the radio
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      powerLevelCode  <= POWER_DEFAULT[1:0];
      serialRateCode  <= RATE_DEFAULT;
      radioRateFast   <= 1'b0;
      hopSetHigh      <= 1'b0;
      addressingStyle <= ADDR_DEFAULT;
    end else begin
      powerLevelCode  <= live[SLOT_POWER][1:0];
      serialRateCode  <= activeRate;
      radioRateFast   <= activeRate >= RATE_FAST_MIN;
      // Codes 0x06/0x07 run below 38400 baud, so they keep the low set
      hopSetHigh      <= (activeRate >= RATE_FAST_MIN) && (activeRate <= RATE_HOPHI_MAX);
      addressingStyle <= live[SLOT_ADDR];
    end
  end
endmodule // radio_cfg_end
`default_nettype wire

// *** src/host_cfg_end.sv ***
// Host end: turns user read/write requests into serial frames
`timescale 1ns/100ps
`default_nettype none
module host_cfg_end
  import radio_cfg_pkg::*;
#(
  parameter int CLK_FREQ      = CLK_HZ,
  parameter bit PC_PORT       = 1'b1,
  parameter int REPLY_TIMEOUT = CLK_FREQ / 1000 * REPLY_WAIT_MS
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Serial link
  serial_link_if.hostEnd  link,
  // Rate selection for hunting
  input  wire logic       rateLoad,
  input  wire logic [7:0] rateValue,
  // Request
  input  wire logic       cmdValid,
  input  wire logic       cmdWrite,
  input  wire logic [7:0] cmdLocation,
  input  wire logic [7:0] cmdData,
  output logic            cmdReady,
  // Answer
  output logic            respValid,
  output logic            respOk,
  output logic [7:0]      respData
);
  // Timeout counter is 24 bits; receiver needs eight clocks a bit
  if (REPLY_TIMEOUT < 1 || REPLY_TIMEOUT > 16777215) begin : g_timeout_check
    $error("REPLY_TIMEOUT out of range");
  end
  if (CLK_FREQ / BAUD_115200 < 8 || CLK_FREQ / BAUD_9600 >= 2 ** BIT_CYC_W) begin : g_clk_check
    $error("CLK_FREQ cannot serve the serial rates");
  end

  typedef enum logic [1:0] {IDLE, SENDING, AWAIT} host_t;

  host_t      state;
  logic [7:0] frame [4];
  logic [1:0] sendIdx;
  logic       sendStarted;
  logic [1:0] gotCount;
  logic [1:0] wantCount;
  logic [7:0] rate;
  logic [7:0] pendingRate;
  logic       rateFollow;
  logic [23:0] waitCount;
  logic       rxValid;
  logic [7:0] rxByte;
  logic       txBusy;
  logic       txStart;
  logic       refuse;

  serial_port port (
    .mclk      (mclk),
    .rstn      (rstn),
    .bitCycles (bit_cycles(rate, CLK_FREQ)),
    .rxPin     (link.radioTx),
    .txPin     (link.hostTx),
    .rxValid   (rxValid),
    .rxByte    (rxByte),
    .txStart   (txStart),
    .txByte    (frame[sendIdx]),
    .txBusy    (txBusy)
  );

  // Writes the host must never issue are answered locally
  always_comb begin
    refuse = cmdWrite && (cmdLocation == ADDRESSING_STYLE_LIVE
                       || cmdLocation == ADDRESSING_STYLE_SAVED);
    if (PC_PORT && cmdWrite && cmdData >= RATE_PC_UNSAFE
        && (cmdLocation == SERIAL_RATE_LIVE || cmdLocation == SERIAL_RATE_SAVED)) begin
      refuse = 1'b1;
    end
  end

  assign txStart = (state == SENDING) && !txBusy && !sendStarted;

  // Request sequencer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state       <= IDLE;
      cmdReady    <= 1'b1;
      respValid   <= 1'b0;
      respOk      <= 1'b0;
      respData    <= 8'h00;
      frame[0]    <= 8'h00;
      frame[1]    <= 8'h00;
      frame[2]    <= 8'h00;
      frame[3]    <= 8'h00;
      sendIdx     <= 2'h0;
      sendStarted <= 1'b0;
      gotCount    <= 2'h0;
      wantCount   <= 2'h0;
      waitCount   <= 24'h000000;
      pendingRate <= 8'h00;
      rateFollow  <= 1'b0;
    end else begin
      respValid <= 1'b0;
      unique case (state)
        IDLE: if (cmdValid) begin
          if (refuse) begin
            respValid <= 1'b1;
            respOk    <= 1'b0;
          end else begin
            cmdReady    <= 1'b0;
            state       <= SENDING;
            sendIdx     <= 2'h0;
            frame[0]    <= FRAME_HEADER;
            frame[1]    <= FRAME_SIZE;
            frame[2]    <= cmdWrite ? cmdLocation : READ_ESCAPE;
            frame[3]    <= cmdWrite ? cmdData : cmdLocation;
            wantCount   <= cmdWrite ? 2'h1 : 2'h3;
            pendingRate <= cmdData;
            rateFollow  <= cmdWrite && cmdLocation == SERIAL_RATE_LIVE;
          end
        end
        SENDING: begin
          if (txStart) begin
            sendStarted <= 1'b1;
          end else if (sendStarted && !txBusy) begin
            sendStarted <= 1'b0;
            sendIdx     <= sendIdx + 2'h1;
            if (sendIdx == 2'h3) begin
              state     <= AWAIT;
              gotCount  <= 2'h0;
              waitCount <= 24'(REPLY_TIMEOUT);
            end
          end
        end
        AWAIT: begin
          waitCount <= waitCount - 24'h000001;
          if (rxValid) begin
            gotCount <= gotCount + 2'h1;
            if (gotCount == 2'h0) respOk <= rxByte == REPLY_ACK;
            respData <= rxByte;
            if (gotCount + 2'h1 == wantCount || (gotCount == 2'h0 && rxByte != REPLY_ACK)) begin
              respValid <= 1'b1;
              cmdReady  <= 1'b1;
              state     <= IDLE;
            end
          end else if (waitCount == 24'h000000) begin
            respValid <= 1'b1;
            respOk    <= 1'b0;
            cmdReady  <= 1'b1;
            state     <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Host rate follows an acknowledged live rate write, or a manual load
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rate <= RATE_DEFAULT;
    end else if (rateLoad && state == IDLE) begin
      rate <= rateValue;
    end else if (state == AWAIT && rxValid && rxByte == REPLY_ACK && rateFollow) begin
      rate <= pendingRate;
    end
  end
endmodule // host_cfg_end
`default_nettype wire

// *** verification/link_monitor.sv ***
// Checker for the two serial lines between host end and radio end
`timescale 1ns/100ps
`default_nettype none
module link_monitor
  import radio_cfg_pkg::*;
#(
  parameter int CLK_FREQ = CLK_HZ
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Serial lines
  input  wire logic hostTx,
  input  wire logic radioTx
);
  logic [19:0] hostRun;
  logic [19:0] radioRun;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Cycles since each line last moved, saturating so long idles never wrap
  // Starts saturated so the first start bit is not taken for a short bit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hostRun  <= 20'hFFFFF;
      radioRun <= 20'hFFFFF;
    end else begin
      if ($changed(hostTx)) hostRun <= 20'h00000;
      else if (!(&hostRun)) hostRun <= hostRun + 20'h00001;
      if ($changed(radioTx)) radioRun <= 20'h00000;
      else if (!(&radioRun)) radioRun <= radioRun + 20'h00001;
    end
  end

  // Start bit of a reply or of a command
  sequence s_radio_start;
    $fell(radioTx);
  endsequence
  sequence s_host_start;
    $fell(hostTx);
  endsequence

  // Bounds from the fastest and slowest rates a PC host may pick
  localparam int MIN_BIT   = CLK_FREQ / BAUD_115200 - 2;
  localparam int MAX_LOW   = 9 * (CLK_FREQ / BAUD_9600) + 4;
  localparam int MIN_GAP   = CLK_FREQ / BAUD_115200 / 2;
  localparam int MAX_QUIET = 40 * (CLK_FREQ / BAUD_9600);

  a_idle_after_reset: assert property ($rose(rstn) |-> hostTx && radioTx)
    else $error("lines not idle high after reset");
  a_host_bit_min: assert property ($changed(hostTx) |-> hostRun >= 20'(MIN_BIT))
    else $error("host bit shorter than fastest rate");
  a_radio_bit_min: assert property ($changed(radioTx) |-> radioRun >= 20'(MIN_BIT))
    else $error("radio bit shorter than fastest rate");
  a_host_low_max: assert property (!hostTx && !$fell(hostTx) |-> hostRun < 20'(MAX_LOW))
    else $error("host line low past a frame");
  a_radio_low_max: assert property (!radioTx && !$fell(radioTx) |-> radioRun < 20'(MAX_LOW))
    else $error("radio line low past a frame");
  a_reply_waits_host: assert property (s_radio_start |-> hostTx)
    else $error("reply started during a command");
  a_host_waits_reply: assert property (s_host_start |-> radioTx && radioRun >= 20'(MIN_GAP))
    else $error("command started during a reply");
  a_reply_follows_cmd: assert property (s_radio_start |-> hostRun < 20'(MAX_QUIET))
    else $error("reply without a recent command");
endmodule // link_monitor
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench joining the host end and the radio end
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import radio_cfg_pkg::*;
  // Ends are told the clock is 2 MHz: same bit ratios, a run fifty times shorter
  localparam int LINK_CLK_HZ = 32'h001E8480;
  logic       mclk;
  logic       rstn;
  logic       rebootReq;
  logic       appAddrWrite;
  logic [7:0] appAddrValue;
  logic       rateLoad;
  logic [7:0] rateValue;
  logic       cmdValid;
  logic       cmdWrite;
  logic [7:0] cmdLocation;
  logic [7:0] cmdData;
  logic       cmdReady;
  logic       respValid;
  logic       respOk;
  logic [7:0] respData;
  logic [1:0] powerLevelCode;
  logic [7:0] serialRateCode;
  logic       radioRateFast;
  logic       hopSetHigh;
  logic [7:0] addressingStyle;
  int         errors;
  int         checks;

  serial_link_if link ();
  // Timeout must cover a three-byte reply at the slowest rate
  host_cfg_end #(.CLK_FREQ(LINK_CLK_HZ), .PC_PORT(1'b1),
                 .REPLY_TIMEOUT(32'h00004E20)) host_cfg_end_inst (
    .mclk(mclk), .rstn(rstn), .link(link.hostEnd), .rateLoad(rateLoad),
    .rateValue(rateValue), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdLocation(cmdLocation), .cmdData(cmdData), .cmdReady(cmdReady),
    .respValid(respValid), .respOk(respOk), .respData(respData));
  radio_cfg_end #(.CLK_FREQ(LINK_CLK_HZ)) radio_cfg_end_inst (
    .mclk(mclk), .rstn(rstn), .link(link.radioEnd), .rebootReq(rebootReq),
    .appAddrWrite(appAddrWrite), .appAddrValue(appAddrValue),
    .powerLevelCode(powerLevelCode), .serialRateCode(serialRateCode),
    .radioRateFast(radioRateFast), .hopSetHigh(hopSetHigh),
    .addressingStyle(addressingStyle));
  link_monitor #(.CLK_FREQ(LINK_CLK_HZ)) link_monitor_inst (
    .mclk(mclk), .rstn(rstn), .hostTx(link.hostTx), .radioTx(link.radioTx));

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One request through the host end; request held until the taking edge
  task automatic cmd(input logic wr, input logic [7:0] loc, input logic [7:0] dat,
                     input logic ok, input logic [7:0] exp);
    int n;
    n = 0;
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdLocation <= loc;
    cmdData <= dat;
    do begin
      @(posedge mclk);
      n++;
    end while (cmdReady !== 1'b1 && n < 100);
    cmdValid <= 1'b0;
    if (cmdReady !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, cmdReady, 1'b1);
      close_out();
    end
    n = 0;
    while (respValid !== 1'b1 && n < 32'h00009C40) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 32'h00009C40) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      close_out();
    end
    chk({7'h00, respOk}, {7'h00, ok});
    if (!wr && ok) chk(respData, exp);
  endtask

  task automatic t_reset();
    chk({6'h00, powerLevelCode}, POWER_DEFAULT);
    chk(serialRateCode, 8'h01);
    chk({6'h00, radioRateFast, hopSetHigh}, 8'h00);
    chk(addressingStyle, 8'h00);
    $display("test reset done");
  endtask

  // Live rate switch to 115200 after the acknowledgement
  task automatic t_rate();
    int n;
    n = 0;
    cmd(1'b1, 8'h4E, 8'h05, 1'b1, 8'h00);
    while (serialRateCode !== 8'h05 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    chk(serialRateCode, 8'h05);
    if (serialRateCode !== 8'h05) close_out();
    chk({6'h00, radioRateFast, hopSetHigh}, 8'h03);
    cmd(1'b0, 8'h4E, 8'h00, 1'b1, 8'h05);
    cmd(1'b1, 8'h4E, 8'h06, 1'b0, 8'h00);
    cmd(1'b1, 8'h03, 8'h07, 1'b0, 8'h00);
    $display("test rate done");
  endtask

  task automatic t_power();
    for (logic [7:0] p = 8'h00; p < 8'h04; p++) begin
      cmd(1'b1, 8'h4D, p, 1'b1, 8'h00);
      cmd(1'b0, 8'h4D, 8'h00, 1'b1, p);
      chk({6'h00, powerLevelCode}, p);
    end
    cmd(1'b1, 8'h4D, 8'h04, 1'b0, 8'h00);
    cmd(1'b0, 8'h4D, 8'h00, 1'b1, 8'h03);
    cmd(1'b1, 8'h02, 8'h01, 1'b1, 8'h00);
    cmd(1'b0, 8'h02, 8'h00, 1'b1, 8'h01);
    chk({6'h00, powerLevelCode}, 8'h03);
    $display("test power done");
  endtask

  // Saved rate, wait timeout, unmapped place
  task automatic t_saved();
    cmd(1'b1, 8'h03, 8'h02, 1'b1, 8'h00);
    cmd(1'b0, 8'h03, 8'h00, 1'b1, 8'h02);
    chk(serialRateCode, 8'h05);
    cmd(1'b1, 8'h50, 8'h07, 1'b1, 8'h00);
    cmd(1'b0, 8'h50, 8'h00, 1'b1, 8'h07);
    cmd(1'b1, 8'h05, 8'h09, 1'b1, 8'h00);
    chk({serialRateCode[5:0], powerLevelCode}, 8'h17);
    cmd(1'b0, 8'h60, 8'h00, 1'b0, 8'h00);
    $display("test saved done");
  endtask

  task automatic t_addr();
    cmd(1'b1, 8'h4F, 8'h01, 1'b0, 8'h00);
    cmd(1'b1, 8'h04, 8'h01, 1'b0, 8'h00);
    appAddrWrite <= 1'b1;
    appAddrValue <= 8'h5A;
    @(posedge mclk);
    appAddrWrite <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(addressingStyle, 8'h5A);
    cmd(1'b0, 8'h4F, 8'h00, 1'b1, 8'h5A);
    $display("test addressing done");
  endtask

  // Soft reset reloads live from saved; host is loaded to match the saved rate
  task automatic t_reboot();
    rebootReq <= 1'b1;
    @(posedge mclk);
    rebootReq <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(serialRateCode, 8'h02);
    chk({6'h00, radioRateFast, hopSetHigh}, 8'h00);
    chk({6'h00, powerLevelCode}, 8'h01);
    rateLoad <= 1'b1;
    rateValue <= 8'h02;
    @(posedge mclk);
    rateLoad <= 1'b0;
    @(posedge mclk);
    cmd(1'b0, 8'h4E, 8'h00, 1'b1, 8'h02);
    cmd(1'b0, 8'h50, 8'h00, 1'b1, 8'h09);
    $display("test reboot done");
  endtask

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    errors = 0;
    checks = 0;
    rstn = 1'b0;
    rebootReq = 1'b0;
    appAddrWrite = 1'b0;
    appAddrValue = 8'h00;
    rateLoad = 1'b0;
    rateValue = 8'h01;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdLocation = 8'h00;
    cmdData = 8'h00;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_rate();
    t_power();
    t_saved();
    t_addr();
    t_reboot();
    close_out();
  end
endmodule // testbench
`default_nettype wire
